// File: src/pwm_cfg_regs.vh
`ifndef PWM_CFG_REGS_VH
`define PWM_CFG_REGS_VH
// Register byte offsets.
`define OFS_CONFIG       8'h00
`define OFS_OVR_ENABLE   8'h04
`define OFS_OVR_LEVEL    8'h08
`define OFS_COMMUT       8'h0c
`define OFS_TB_LO        8'h20
`define OFS_TB_A_HI      8'h27
`define OFS_TB_BC_LO     8'h28
`define OFS_TB_BC_HI     8'h37
// Configuration field positions.
`define CFG_PROTECT      7
`define CFG_MULTI_TB     6
`define CFG_ALIGN_C      5
`define CFG_ALIGN_B      4
`define CFG_ALIGN_A      3
`define CFG_INDEP_C      2
// Commutation control field positions.
`define CMT_BUF_EN       0
// Reset values.
`define RST_CONFIG       8'h00
`define RST_OVR          6'h00
// AXI responses.
`define RESP_OKAY        2'b00
`define RESP_DECERR      2'b11
`endif

// File: src/pwm_config_and_sw_override.v
`timescale 1ns/100ps
`default_nettype none
`include "pwm_cfg_regs.vh"
module pwm_config_and_sw_override #(
  parameter CHANNELS = 6
) (
  // Clock and reset.
  input  wire                aclk,
  input  wire                aresetn,
  // AXI4-Lite write address.
  input  wire [7:0]          s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output wire                s_axi_awready,
  // AXI4-Lite write data.
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output wire                s_axi_wready,
  // AXI4-Lite write response.
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  // AXI4-Lite read address.
  input  wire [7:0]          s_axi_araddr,
  input  wire                s_axi_arvalid,
  output wire                s_axi_arready,
  // AXI4-Lite read data.
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  // Generator side.
  input  wire [CHANNELS-1:0] gen_pwm,
  input  wire                pwm_cycle_start,
  input  wire                commutation_start,
  // Timebase window register port, owned by the counter logic.
  output wire                tb_wr_en,
  output wire [7:0]          tb_wr_addr,
  output wire [7:0]          tb_wr_data,
  input  wire [7:0]          tb_rd_data,
  // Configuration to the generators.
  output wire                multi_timebase_select,
  output wire                pair_a_edge,
  output wire                pair_b_edge,
  output wire                pair_c_edge,
  output wire                pair_c_independent,
  // Outputs to the gate driver.
  output reg  [CHANNELS-1:0] pwm_out
);

  reg  [7:0]          config_q;
  reg  [CHANNELS-1:0] ovr_buf_q;
  reg  [CHANNELS-1:0] ovr_act_q;
  reg  [CHANNELS-1:0] level_q;
  reg                 cmt_buf_q;
  reg  [7:0]          aw_addr_q;
  reg                 aw_have_q;
  reg  [31:0]         w_data_q;
  reg  [3:0]          w_strb_q;
  reg                 w_have_q;

  wire       protect = config_q[`CFG_PROTECT];
  wire       do_wr   = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [7:0] wd      = w_data_q[7:0];
  wire       wlane   = w_strb_q[0];
  wire       in_tb_a  = (aw_addr_q >= `OFS_TB_LO) && (aw_addr_q <= `OFS_TB_A_HI);
  wire       in_tb_bc = (aw_addr_q >= `OFS_TB_BC_LO) && (aw_addr_q <= `OFS_TB_BC_HI);
  wire       wr_known = (aw_addr_q == `OFS_CONFIG) || (aw_addr_q == `OFS_OVR_ENABLE) ||
                        (aw_addr_q == `OFS_OVR_LEVEL) || (aw_addr_q == `OFS_COMMUT) ||
                        in_tb_a || in_tb_bc;
  wire       wr_ovr  = do_wr && wlane && (aw_addr_q == `OFS_OVR_ENABLE);

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Timebase window writes pass through; B/C space is closed under one timebase.
  assign tb_wr_en   = do_wr && wlane && (in_tb_a || (in_tb_bc && config_q[`CFG_MULTI_TB]));
  assign tb_wr_addr = aw_addr_q;
  assign tb_wr_data = wd;

  assign multi_timebase_select = config_q[`CFG_MULTI_TB];
  assign pair_a_edge        = config_q[`CFG_ALIGN_A];
  assign pair_b_edge        = config_q[`CFG_MULTI_TB] ? config_q[`CFG_ALIGN_B]
                                                      : config_q[`CFG_ALIGN_A];
  assign pair_c_edge        = config_q[`CFG_MULTI_TB] ? config_q[`CFG_ALIGN_C]
                                                      : config_q[`CFG_ALIGN_A];
  assign pair_c_independent = config_q[`CFG_INDEP_C];

  // Bus write side; address and data are latched separately in either order.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (do_wr)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Protected writes still answer OKAY so drivers need no special path.
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Registers; the protect bit is sticky and guards the configuration register only.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_q  <= `RST_CONFIG;
      cmt_buf_q <= 1'b0;
      level_q   <= `RST_OVR;
    end
    else if (do_wr && wlane)
    begin
      if (aw_addr_q == `OFS_CONFIG && !protect)
        config_q <= {wd[7:2], 2'b00};
      if (aw_addr_q == `OFS_COMMUT)
        cmt_buf_q <= wd[`CMT_BUF_EN];
      if (aw_addr_q == `OFS_OVR_LEVEL)
        level_q <= wd[CHANNELS-1:0];
    end
  end

  // Override enables. Buffered mode loads only at commutation start.
  // Unbuffered mode sets at once but releases at the PWM cycle start to avoid slivers.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovr_buf_q <= `RST_OVR;
      ovr_act_q <= `RST_OVR;
    end
    else
    begin
      if (wr_ovr)
        ovr_buf_q <= wd[CHANNELS-1:0];
      if (cmt_buf_q)
      begin
        if (commutation_start)
          ovr_act_q <= ovr_buf_q;
      end
      else if (wr_ovr)
        ovr_act_q <= ovr_act_q | wd[CHANNELS-1:0];
      else if (pwm_cycle_start)
        ovr_act_q <= ovr_buf_q;
    end
  end

  // Output mux; the pairing of enables is left to software.
  always @(posedge aclk)
  begin
    if (!aresetn)
      pwm_out <= `RST_OVR;
    else
      pwm_out <= (ovr_act_q & level_q) | (~ovr_act_q & gen_pwm);
  end

  // Read side.
  reg [31:0] rd_d;
  reg [1:0]  rresp_d;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  always @*
  begin
    rd_d    = 32'h00000000;
    rresp_d = `RESP_OKAY;
    if (ra == `OFS_CONFIG)
      rd_d[7:0] = config_q;
    else if (ra == `OFS_OVR_ENABLE)
      rd_d[CHANNELS-1:0] = ovr_buf_q;
    else if (ra == `OFS_OVR_LEVEL)
      rd_d[CHANNELS-1:0] = (ovr_act_q & level_q) | (~ovr_act_q & pwm_out);
    else if (ra == `OFS_COMMUT)
      rd_d[0] = cmt_buf_q;
    else if (ra >= `OFS_TB_LO && ra <= `OFS_TB_A_HI)
      rd_d[7:0] = tb_rd_data;
    else if (ra >= `OFS_TB_BC_LO && ra <= `OFS_TB_BC_HI)
      rd_d[7:0] = config_q[`CFG_MULTI_TB] ? tb_rd_data : 8'h00;
    else
      rresp_d = `RESP_DECERR;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rresp_d;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // pwm_config_and_sw_override
`default_nettype wire

// File: test/gate_driver_model.sv
`timescale 1ns/100ps
`default_nettype none
module gate_driver_model (
  // Clock and gate inputs.
  input  wire logic       aclk,
  input  wire logic [5:0] pwm_in,
  // Gate levels, one clock behind as a registered pre-driver shows them.
  output var  logic [5:0] gate_q
);
  always_ff @(posedge aclk) gate_q <= pwm_in;
endmodule // gate_driver_model
`default_nettype wire

// File: test/pwm_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pwm_checker (
  // Bus handshakes and configuration outputs, grouped to keep the list short.
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic        tb_wr_en, multi_timebase_select,
  input wire logic        pair_a_edge, pair_b_edge, pair_c_edge,
  input wire logic [7:0]  tb_wr_addr,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data missing");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  a_single_tb: assert property (!multi_timebase_select |-> pair_b_edge == pair_a_edge && pair_c_edge == pair_a_edge)
    else $error("pair alignment not following pair A");
  a_tb_gate: assert property (tb_wr_en && tb_wr_addr >= 8'h28 |-> multi_timebase_select)
    else $error("timebase window written in single mode");
endmodule // pwm_checker
bind pwm_config_and_sw_override pwm_checker u_chk (.*);
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, pwm_cycle_start = 0, commutation_start = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        tb_wr_en, multi_timebase_select, pair_a_edge, pair_b_edge, pair_c_edge;
  logic        pair_c_independent;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, tb_rd_data = 8'h5a, tb_wr_addr, tb_wr_data;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  gen_pwm = 6'h2a, pwm_out, gate_q;
  int          mismatches = 0, total_checks = 0, cyc = 0;
  pwm_config_and_sw_override uut (.*);
  gate_driver_model drv (.aclk(aclk), .pwm_in(pwm_out), .gate_q(gate_q));
  initial forever #12.5 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Every handshake is judged at the rising edge; one idle edge separates transfers.
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    logic dn;
    logic [1:0] r;
    dn = 0;
    r = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!dn)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 0;
      if (s_axi_bvalid)
      begin
        dn = 1;
        r = s_axi_bresp;
        s_axi_bready <= 0;
      end
    end
    @(posedge aclk);
    chk("bresp", er, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic dn;
    logic [31:0] d;
    logic [1:0] r;
    dn = 0;
    d = 32'h0;
    r = 2'b00;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!dn)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 0;
      if (s_axi_rvalid)
      begin
        dn = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    @(posedge aclk);
    chk("rdata", ed, d);
    chk("rresp", er, r);
  endtask
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic t_config;
    rd(8'h00, 0, 0);
    rd(8'h04, 0, 0);
    wr(8'h00, 8'h7c, 0);
    rd(8'h00, 32'h7c, 0);
    rd(8'h28, 32'h5a, 0);
    settle;
    chk("cfg", 5'h1f, {multi_timebase_select, pair_a_edge, pair_b_edge, pair_c_edge, pair_c_independent});
    wr(8'h00, 8'h30, 0);
    wr(8'h28, 8'h11, 0);
    rd(8'h28, 0, 0);
    chk("cfg", 5'h00, {multi_timebase_select, pair_a_edge, pair_b_edge, pair_c_edge, pair_c_independent});
    wr(8'h00, 8'h08, 0);
    settle;
    chk("edges", 3'h7, {pair_a_edge, pair_b_edge, pair_c_edge});
    wr(8'h10, 8'h01, 2'b11);
    rd(8'h10, 0, 2'b11);
    $display("config test done");
  endtask
  task automatic t_override;
    wr(8'h08, 8'h15, 0);
    wr(8'h04, 8'h03, 0);
    settle;
    chk("pwm_out", 6'h29, pwm_out);
    rd(8'h08, 32'h29, 0);
    wr(8'h04, 8'h00, 0);
    settle;
    chk("pwm_out", 6'h29, pwm_out);
    pwm_cycle_start <= 1;
    @(posedge aclk);
    pwm_cycle_start <= 0;
    settle;
    chk("pwm_out", 6'h2a, pwm_out);
    chk("gate_q", 6'h2a, gate_q);
    $display("override test done");
  endtask
  task automatic t_buffer;
    wr(8'h0c, 8'h01, 0);
    wr(8'h04, 8'h0c, 0);
    settle;
    chk("pwm_out", 6'h2a, pwm_out);
    rd(8'h04, 32'h0c, 0);
    commutation_start <= 1;
    @(posedge aclk);
    commutation_start <= 0;
    settle;
    chk("pwm_out", 6'h26, pwm_out);
    $display("buffer test done");
  endtask
  task automatic t_protect;
    wr(8'h00, 8'hc0, 0);
    wr(8'h00, 8'h3c, 0);
    wr(8'h00, 8'h00, 0);
    rd(8'h00, 32'hc0, 0);
    chk("multi", 1'b1, multi_timebase_select);
    // Only a reset may lift the protection, so one is given in mid-run.
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h00, 0, 0);
    $display("protect test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      mismatches++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_config;
    t_override;
    t_buffer;
    t_protect;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
